/* design/vref_pkg.sv */
// Package: register map, field layout, reset values and timing for the reference control block
package vref_pkg;

  // ------------------------------------------------------------
  // Register offsets on the local register port
  // ------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFF_FIXED_REFERENCE_CONTROL = 2'h0;
  localparam logic [1:0] OFF_DAC_CONTROL = 2'h1;
  localparam logic [1:0] OFF_DAC_LEVEL_SELECT = 2'h2;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_FIXED_REF_ENABLE = 7;
  localparam int BIT_FIXED_REF_STABLE = 6;
  localparam int BIT_DAC_ENABLE = 7;
  localparam int BIT_DAC_LPS = 6;
  localparam int BIT_DAC_PIN_OE = 5;
  localparam int BIT_DAC_NSS = 0;
  localparam int LEVEL_W = 5;
  localparam int TAP_W = 6;

  // ------------------------------------------------------------
  // Reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_FIXED_REFERENCE_CONTROL = 8'h10;
  localparam logic [7:0] RST_DAC_CONTROL = 8'h00;
  localparam logic [7:0] RST_DAC_LEVEL_SELECT = 8'h00;
  localparam logic [7:0] WMASK_FIXED_REFERENCE_CONTROL = 8'hb0;
  localparam logic [7:0] WMASK_DAC_CONTROL = 8'hed;
  localparam logic [7:0] WMASK_DAC_LEVEL_SELECT = 8'h1f;

  // ------------------------------------------------------------
  // Source and gain encodings
  // ------------------------------------------------------------
  localparam logic [1:0] PSS_SUPPLY = 2'h0;
  localparam logic [1:0] PSS_EXT_POS = 2'h1;
  localparam logic [1:0] PSS_FIXED_REF = 2'h2;
  localparam logic [1:0] GAIN_X1 = 2'h1;
  localparam logic [1:0] GAIN_X2 = 2'h2;
  localparam logic [1:0] GAIN_X4 = 2'h3;
  localparam logic [5:0] TAP_FULL = 6'h20;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLOCK_MHZ = 25;
  localparam int FIXED_REF_SETTLE_NS = 25000;
  localparam int FIXED_REF_SETTLE_CYC = (FIXED_REF_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SETTLE_CNT_W = 16;

  // ------------------------------------------------------------
  // Register layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic stable;
    logic [1:0] gain;
    logic [3:0] unused;
  } fixed_ref_ctrl_t;

  typedef struct packed {
    logic enable;
    logic low_power_state;
    logic pin_output_enable;
    logic unused4;
    logic [1:0] positive_source;
    logic unused1;
    logic negative_source;
  } dac_ctrl_t;

  typedef struct packed {
    logic [2:0] unused;
    logic [4:0] code;
  } dac_level_t;

endpackage : vref_pkg

/* design/sync_two_flop.sv */
// Two-flop synchroniser for levels entering the register clock domain
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule : sync_two_flop

/* design/masked_reg.sv */
// Byte register with a writable mask; unwritable bits stay zero
`timescale 1ns/1ps
module masked_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);

  logic [7:0] val_r;
  logic [7:0] val_nxt;

  // Masked bits never take a write, so they read back as zero
  always_comb begin
    val_nxt = val_r;
    if (we) begin
      val_nxt = wdata & WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      val_r <= RESET_VAL & WMASK;
    end else begin
      val_r <= val_nxt;
    end
  end

  assign q = val_r;

endmodule : masked_reg

/* design/voltage_reference_control_regs.sv */
// Control registers and digital steering for the programmable and fixed voltage references
`timescale 1ns/1ps
module voltage_reference_control_regs
  import vref_pkg::*;
#(
  parameter int SETTLE_CYCLES = FIXED_REF_SETTLE_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic FIXED_REF_SETTLED,
  input wire logic PIN_DIN,
  input wire logic PORT_DOUT,
  input wire logic PORT_OE_B,
  input wire logic SLEEP,
  output logic DAC_ENABLE,
  output logic DAC_LOW_POWER_STATE_SELECT,
  output logic DAC_PIN_OUTPUT_ENABLE,
  output logic [1:0] DAC_POSITIVE_SOURCE_SELECT,
  output logic DAC_NEGATIVE_SOURCE_SELECT,
  output logic [LEVEL_W-1:0] DAC_LEVEL_CODE,
  output logic [TAP_W-1:0] DAC_TAP,
  output logic [2:0] DAC_POSITIVE_SOURCE_ONEHOT,
  output logic FIXED_REF_ENABLE,
  output logic [1:0] FIXED_REF_GAIN_SELECT,
  output logic [2:0] FIXED_REF_GAIN_ONEHOT,
  output logic PIN_ANALOG_CONNECT,
  output logic PIN_DOUT,
  output logic PIN_OE_B,
  output logic PIN_READ_DATA
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic we_fixed;
  logic we_dac;
  logic we_level;
  logic [7:0] fixed_raw;
  logic [7:0] dac_raw;
  logic [7:0] level_raw;
  fixed_ref_ctrl_t fixed_q;
  dac_ctrl_t dac_q;
  dac_level_t level_q;
  logic settled_sync;
  logic pin_din_sync;
  logic [SETTLE_CNT_W-1:0] settle_cnt_r;
  logic [SETTLE_CNT_W-1:0] settle_cnt_nxt;
  logic stable_r;
  logic stable_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic dac_en_r;
  logic dac_en_nxt;
  logic lps_r;
  logic lps_nxt;
  logic pin_oe_r;
  logic pin_oe_nxt;
  logic [1:0] pss_r;
  logic [1:0] pss_nxt;
  logic nss_r;
  logic nss_nxt;
  logic [LEVEL_W-1:0] code_r;
  logic [LEVEL_W-1:0] code_nxt;
  logic [TAP_W-1:0] tap_r;
  logic [TAP_W-1:0] tap_nxt;
  logic [2:0] pss_onehot_r;
  logic [2:0] pss_onehot_nxt;
  logic fref_en_r;
  logic fref_en_nxt;
  logic [1:0] gain_r;
  logic [1:0] gain_nxt;
  logic [2:0] gain_onehot_r;
  logic [2:0] gain_onehot_nxt;
  logic analog_conn_r;
  logic analog_conn_nxt;
  logic pin_dout_r;
  logic pin_dout_nxt;
  logic pin_oe_b_r;
  logic pin_oe_b_nxt;
  logic pin_rd_r;
  logic pin_rd_nxt;

  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(SETTLE_CYCLES);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // Write decode; the bus never waits, so a strobe lands in its own cycle
  assign we_fixed = WR && (ADDR == OFF_FIXED_REFERENCE_CONTROL);
  assign we_dac = WR && (ADDR == OFF_DAC_CONTROL);
  assign we_level = WR && (ADDR == OFF_DAC_LEVEL_SELECT);

  // Only the async reset clears these; a sleep input has no path in, so wake keeps them
  masked_reg #(
    .RESET_VAL(RST_FIXED_REFERENCE_CONTROL),
    .WMASK(WMASK_FIXED_REFERENCE_CONTROL)
  ) u_fixed_reg (
    .clk(CLOCK),
    .rst_b(RST_B),
    .we(we_fixed),
    .wdata(WDATA),
    .q(fixed_raw)
  );

  // Bits 4 and 1 are masked off
  masked_reg #(
    .RESET_VAL(RST_DAC_CONTROL),
    .WMASK(WMASK_DAC_CONTROL)
  ) u_dac_reg (
    .clk(CLOCK),
    .rst_b(RST_B),
    .we(we_dac),
    .wdata(WDATA),
    .q(dac_raw)
  );

  // Code kept right-justified, upper three bits masked
  masked_reg #(
    .RESET_VAL(RST_DAC_LEVEL_SELECT),
    .WMASK(WMASK_DAC_LEVEL_SELECT)
  ) u_level_reg (
    .clk(CLOCK),
    .rst_b(RST_B),
    .we(we_level),
    .wdata(WDATA),
    .q(level_raw)
  );

  assign fixed_q = fixed_ref_ctrl_t'(fixed_raw);
  assign dac_q = dac_ctrl_t'(dac_raw);
  assign level_q = dac_level_t'(level_raw);

  // ------------------------------------------------------------
  // Synchronisers for the analog settle flag and the pad input
  // ------------------------------------------------------------
  sync_two_flop #(
    .W(1)
  ) u_settled_sync (
    .clk(CLOCK),
    .rst_b(RST_B),
    .d(FIXED_REF_SETTLED),
    .q(settled_sync)
  );

  sync_two_flop #(
    .W(1)
  ) u_pin_sync (
    .clk(CLOCK),
    .rst_b(RST_B),
    .d(PIN_DIN),
    .q(pin_din_sync)
  );

  // ------------------------------------------------------------
  // Fixed reference settling
  // ------------------------------------------------------------
  // The flag needs both a minimum on-time and the analog settled level, so a
  // slow or missing analog indication can never report early
  always_comb begin
    settle_cnt_nxt = settle_cnt_r;
    stable_nxt = 1'b0;
    if (!fixed_q.enable) begin
      settle_cnt_nxt = '0;
    end else if (settle_cnt_r != SETTLE_LAST) begin
      settle_cnt_nxt = settle_cnt_r + SETTLE_CNT_W'(1);
    end
    if (fixed_q.enable && (settle_cnt_r == SETTLE_LAST) && settled_sync) begin
      stable_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      settle_cnt_r <= '0;
      stable_r <= 1'b0;
    end else begin
      settle_cnt_r <= settle_cnt_nxt;
      stable_r <= stable_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Data stands only in the cycle after the read strobe; unmapped reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (RD) begin
      case (ADDR)
        OFF_FIXED_REFERENCE_CONTROL: begin
          rdata_nxt = fixed_raw;
          rdata_nxt[BIT_FIXED_REF_STABLE] = stable_r && fixed_q.enable;
        end
        OFF_DAC_CONTROL: begin
          rdata_nxt = dac_raw;
        end
        OFF_DAC_LEVEL_SELECT: begin
          rdata_nxt = level_raw;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // DAC steering
  // ------------------------------------------------------------
  // Tap counts in 1/32 steps of the span; TAP_FULL means the positive rail.
  // Reserved positive code 11 selects no source at all rather than a guess.
  always_comb begin
    dac_en_nxt = dac_q.enable;
    lps_nxt = dac_q.low_power_state;
    pin_oe_nxt = dac_q.pin_output_enable;
    pss_nxt = dac_q.positive_source;
    nss_nxt = dac_q.negative_source;
    code_nxt = level_q.code;
    if (dac_q.enable) begin
      tap_nxt = {1'b0, level_q.code};
    end else if (dac_q.low_power_state) begin
      tap_nxt = TAP_FULL;
    end else begin
      tap_nxt = '0;
    end
    case (dac_q.positive_source)
      PSS_SUPPLY: begin
        pss_onehot_nxt = 3'h1;
      end
      PSS_EXT_POS: begin
        pss_onehot_nxt = 3'h2;
      end
      PSS_FIXED_REF: begin
        pss_onehot_nxt = 3'h4;
      end
      default: begin
        pss_onehot_nxt = 3'h0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Fixed reference steering
  // ------------------------------------------------------------
  // Reserved gain 00 leaves every gain leg off
  always_comb begin
    fref_en_nxt = fixed_q.enable;
    gain_nxt = fixed_q.gain;
    case (fixed_q.gain)
      GAIN_X1: begin
        gain_onehot_nxt = 3'h1;
      end
      GAIN_X2: begin
        gain_onehot_nxt = 3'h2;
      end
      GAIN_X4: begin
        gain_onehot_nxt = 3'h4;
      end
      default: begin
        gain_onehot_nxt = 3'h0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Shared pin
  // ------------------------------------------------------------
  // In reference mode the port driver is released and the digital read is
  // forced low, so the analog level never reaches the input detector
  always_comb begin
    analog_conn_nxt = dac_q.pin_output_enable;
    if (dac_q.pin_output_enable) begin
      pin_dout_nxt = 1'b0;
      pin_oe_b_nxt = 1'b1;
      pin_rd_nxt = 1'b0;
    end else begin
      pin_dout_nxt = PORT_DOUT;
      pin_oe_b_nxt = PORT_OE_B;
      pin_rd_nxt = pin_din_sync;
    end
  end

  // Output flops; reset leaves both references off and the pin disconnected
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      dac_en_r <= 1'b0;
      lps_r <= 1'b0;
      pin_oe_r <= 1'b0;
      pss_r <= 2'h0;
      nss_r <= 1'b0;
      code_r <= '0;
      tap_r <= '0;
      pss_onehot_r <= 3'h1;
      fref_en_r <= 1'b0;
      gain_r <= 2'h1;
      gain_onehot_r <= 3'h1;
      analog_conn_r <= 1'b0;
      pin_dout_r <= 1'b0;
      pin_oe_b_r <= 1'b1;
      pin_rd_r <= 1'b0;
    end else begin
      dac_en_r <= dac_en_nxt;
      lps_r <= lps_nxt;
      pin_oe_r <= pin_oe_nxt;
      pss_r <= pss_nxt;
      nss_r <= nss_nxt;
      code_r <= code_nxt;
      tap_r <= tap_nxt;
      pss_onehot_r <= pss_onehot_nxt;
      fref_en_r <= fref_en_nxt;
      gain_r <= gain_nxt;
      gain_onehot_r <= gain_onehot_nxt;
      analog_conn_r <= analog_conn_nxt;
      pin_dout_r <= pin_dout_nxt;
      pin_oe_b_r <= pin_oe_b_nxt;
      pin_rd_r <= pin_rd_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // SLEEP is accepted for completeness only; the registers ignore it
  assign RDATA = rdata_r;
  assign DAC_ENABLE = dac_en_r;
  assign DAC_LOW_POWER_STATE_SELECT = lps_r;
  assign DAC_PIN_OUTPUT_ENABLE = pin_oe_r;
  assign DAC_POSITIVE_SOURCE_SELECT = pss_r;
  assign DAC_NEGATIVE_SOURCE_SELECT = nss_r;
  assign DAC_LEVEL_CODE = code_r;
  assign DAC_TAP = tap_r;
  assign DAC_POSITIVE_SOURCE_ONEHOT = pss_onehot_r;
  assign FIXED_REF_ENABLE = fref_en_r;
  assign FIXED_REF_GAIN_SELECT = gain_r;
  assign FIXED_REF_GAIN_ONEHOT = gain_onehot_r;
  assign PIN_ANALOG_CONNECT = analog_conn_r;
  assign PIN_DOUT = pin_dout_r;
  assign PIN_OE_B = pin_oe_b_r;
  assign PIN_READ_DATA = pin_rd_r;

endmodule : voltage_reference_control_regs

/* test/voltage_reference_control_regs_sva.sv */
// Checker: port assertions for the reference control registers
`timescale 1ns/1ps
module vref_regs_checker
  import vref_pkg::*;
#(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic DAC_ENABLE,
  input wire logic DAC_LOW_POWER_STATE_SELECT,
  input wire logic DAC_PIN_OUTPUT_ENABLE,
  input wire logic [1:0] DAC_POSITIVE_SOURCE_SELECT,
  input wire logic [LEVEL_W-1:0] DAC_LEVEL_CODE,
  input wire logic [TAP_W-1:0] DAC_TAP,
  input wire logic [2:0] DAC_POSITIVE_SOURCE_ONEHOT,
  input wire logic FIXED_REF_ENABLE,
  input wire logic PIN_ANALOG_CONNECT,
  input wire logic PIN_DOUT,
  input wire logic PIN_OE_B,
  input wire logic PIN_READ_DATA
);
  localparam int SETTLE_MIN = SETTLE_CYCLES - 2;
  logic [15:0] on_cnt_r;
  logic [15:0] on_cnt_nxt;

  // ------------------------------------------------------------
  // Cycles the fixed reference has been on, saturating
  // ------------------------------------------------------------
  always_comb begin
    on_cnt_nxt = on_cnt_r;
    if (!FIXED_REF_ENABLE) on_cnt_nxt = 16'h0000;
    else if (on_cnt_r != 16'hffff) on_cnt_nxt = on_cnt_r + 16'h0001;
  end
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) on_cnt_r <= 16'h0000;
    else on_cnt_r <= on_cnt_nxt;
  end

  // Bits that must read zero at each offset
  function automatic logic [7:0] dead_bits(input logic [1:0] a);
    case (a)
      2'h0: dead_bits = 8'h0f;
      2'h1: dead_bits = 8'h12;
      2'h2: dead_bits = 8'he0;
      default: dead_bits = 8'hff;
    endcase
  endfunction : dead_bits

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  sequence s_wr_dac;
    WR && ADDR == OFF_DAC_CONTROL;
  endsequence
  sequence s_wr_lvl;
    WR && ADDR == OFF_DAC_LEVEL_SELECT;
  endsequence

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Stability guards let registered outputs lag their fields by one cycle
  AST_DAC_WRITE: assert property (s_wr_dac |-> ##2 DAC_ENABLE == $past(WDATA[7], 2))
    else $error("dac enable did not follow the write");
  AST_LEVEL_WRITE: assert property (s_wr_lvl |-> ##2 DAC_LEVEL_CODE == $past(WDATA[4:0], 2))
    else $error("level code did not follow the write");
  AST_TAP_ON: assert property (DAC_ENABLE && $stable(DAC_ENABLE) && $stable(DAC_LEVEL_CODE)
    |-> DAC_TAP == {1'b0, DAC_LEVEL_CODE}) else $error("tap differs from level code");
  AST_TAP_OFF: assert property (!DAC_ENABLE && $stable(DAC_ENABLE) && $stable(DAC_LOW_POWER_STATE_SELECT)
    |-> DAC_TAP == (DAC_LOW_POWER_STATE_SELECT ? TAP_FULL : 6'h00)) else $error("disabled tap wrong");
  AST_POS_ONEHOT: assert property ($stable(DAC_POSITIVE_SOURCE_SELECT) |-> DAC_POSITIVE_SOURCE_ONEHOT ==
    (DAC_POSITIVE_SOURCE_SELECT == 2'h3 ? 3'h0 : 3'h1 << DAC_POSITIVE_SOURCE_SELECT))
    else $error("positive source decode wrong");
  AST_PIN_OVERRIDE: assert property (DAC_PIN_OUTPUT_ENABLE && $stable(DAC_PIN_OUTPUT_ENABLE)
    |-> PIN_OE_B && !PIN_DOUT && PIN_ANALOG_CONNECT) else $error("pin buffer not overridden");
  AST_PIN_READ_ZERO: assert property (DAC_PIN_OUTPUT_ENABLE && $stable(DAC_PIN_OUTPUT_ENABLE)
    |-> !PIN_READ_DATA) else $error("pin read not zero in reference mode");
  AST_UNIMPL: assert property ($past(RD) |-> (RDATA & dead_bits($past(ADDR))) == 8'h00)
    else $error("unimplemented bits read nonzero");
  AST_STABLE_EARLY: assert property ($past(RD) && $past(ADDR) == OFF_FIXED_REFERENCE_CONTROL
    && RDATA[BIT_FIXED_REF_STABLE] |-> $past(on_cnt_r, 2) >= SETTLE_MIN) else $error("stable flag early");
endmodule : vref_regs_checker

/* test/analog_ref_model.sv */
// Partner: behavioural fixed reference settling and shared pad
`timescale 1ns/1ps
module analog_ref_model #(
  parameter int SETTLE_DELAY = 4
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic FIXED_REF_ENABLE,
  input wire logic hold_off,
  input wire logic PIN_ANALOG_CONNECT,
  input wire logic PIN_DOUT,
  input wire logic PIN_OE_B,
  input wire logic ext_level,
  output logic FIXED_REF_SETTLED,
  output logic PIN_DIN
);
  int warm = 0;
  logic wobble = 1'b0;

  // Warm-up count restarts whenever the reference is switched off
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B || !FIXED_REF_ENABLE) warm <= 0;
    else if (warm < SETTLE_DELAY) warm <= warm + 1;
  end
  always @(posedge CLOCK) wobble <= !wobble;

  // hold_off plays a slow circuit that never settles
  assign FIXED_REF_SETTLED = FIXED_REF_ENABLE && !hold_off && warm >= SETTLE_DELAY;
  // An analog level has no logic value, so the pad toggles every cycle
  assign PIN_DIN = PIN_ANALOG_CONNECT ? wobble : (!PIN_OE_B ? PIN_DOUT : ext_level);
endmodule : analog_ref_model

/* test/voltage_reference_control_regs_tb_top.sv */
// Testbench: register access, steering, pin override and settle flag
`timescale 1ns/1ps
module voltage_reference_control_regs_tb_top;
  import vref_pkg::*;
  localparam int SETTLE = 8;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic [ADDR_W-1:0] ADDR = '0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic PORT_DOUT = 1'b1;
  logic PORT_OE_B = 1'b0;
  logic SLEEP = 1'b0;
  logic hold_off = 1'b0;
  logic ext_level = 1'b0;
  logic [7:0] RDATA;
  logic FIXED_REF_SETTLED, PIN_DIN, DAC_ENABLE, DAC_LOW_POWER_STATE_SELECT, DAC_PIN_OUTPUT_ENABLE;
  logic DAC_NEGATIVE_SOURCE_SELECT, FIXED_REF_ENABLE, PIN_ANALOG_CONNECT, PIN_DOUT, PIN_OE_B, PIN_READ_DATA;
  logic [1:0] DAC_POSITIVE_SOURCE_SELECT, FIXED_REF_GAIN_SELECT;
  logic [4:0] DAC_LEVEL_CODE;
  logic [5:0] DAC_TAP;
  logic [2:0] DAC_POSITIVE_SOURCE_ONEHOT, FIXED_REF_GAIN_ONEHOT;
  int miscompares = 0;
  int checked = 0;

  voltage_reference_control_regs #(.SETTLE_CYCLES(SETTLE)) u_voltage_reference_control_regs (.*);
  analog_ref_model u_analog_ref_model (.*);

  initial begin
    forever #20 CLOCK = !CLOCK;
  end

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr
  task automatic rdchk(input string what, input logic [1:0] a, input logic [7:0] exp);
    @(posedge CLOCK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 chk(what, RDATA, exp);
  endtask : rdchk
  task automatic idle(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : idle
  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Watchdog: the tests need under two hundred cycles
  initial begin
    #(40 * 3000);
    miscompares++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    logic [7:0] masks [4];
    masks = '{WMASK_FIXED_REFERENCE_CONTROL, WMASK_DAC_CONTROL, WMASK_DAC_LEVEL_SELECT, 8'h00};
    repeat (2) @(posedge CLOCK);
    RST_B <= 1'b1;
    rdchk("fixed_reference_control", OFF_FIXED_REFERENCE_CONTROL, RST_FIXED_REFERENCE_CONTROL);
    rdchk("dac_control", OFF_DAC_CONTROL, RST_DAC_CONTROL);
    rdchk("dac_level_select", OFF_DAC_LEVEL_SELECT, RST_DAC_LEVEL_SELECT);
    chk("enables", {5'h0, DAC_ENABLE, FIXED_REF_ENABLE, PIN_ANALOG_CONNECT}, 8'h00);
    $display("test reset done");
    // All ones everywhere; fixed control last so its flag is read before settling
    for (int a = 3; a >= 0; a--) wr(a[1:0], 8'hff);
    for (int a = 0; a < 4; a++) rdchk("masked readback", a[1:0], masks[a]);
    chk("level code", {3'h0, DAC_LEVEL_CODE}, 8'h1f);
    chk("tap", {2'h0, DAC_TAP}, 8'h1f);
    chk("gain onehot", {5'h0, FIXED_REF_GAIN_ONEHOT}, 8'h04);
    chk("pin override", {3'h0, PIN_ANALOG_CONNECT, DAC_PIN_OUTPUT_ENABLE, PIN_OE_B, PIN_DOUT, PIN_READ_DATA}, 8'h1c);
    wr(OFF_DAC_CONTROL, 8'h00);
    idle(5);
    chk("pin released", {3'h0, PIN_ANALOG_CONNECT, DAC_PIN_OUTPUT_ENABLE, PIN_OE_B, PIN_DOUT, PIN_READ_DATA}, 8'h03);
    // Port lets go of the pin, so the digital read follows the outside level
    PORT_OE_B <= 1'b1;
    PORT_DOUT <= 1'b0;
    ext_level <= 1'b1;
    idle(5);
    chk("pin input", {5'h0, PIN_OE_B, PIN_DOUT, PIN_READ_DATA}, 8'h05);
    $display("test masks done");
    // Every source and gain code, with enable and low-power select swept
    wr(OFF_DAC_LEVEL_SELECT, 8'hf5);
    rdchk("level right justified", OFF_DAC_LEVEL_SELECT, 8'h15);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_DAC_CONTROL, {i[0], i[1], 2'h0, i[1:0], 1'b0, i[0]});
      wr(OFF_FIXED_REFERENCE_CONTROL, {2'h0, i[1:0], 4'h0});
      idle(2);
      chk("pos select", {6'h0, DAC_POSITIVE_SOURCE_SELECT}, {6'h0, i[1:0]});
      chk("pos onehot", {5'h0, DAC_POSITIVE_SOURCE_ONEHOT}, (i == 3) ? 8'h00 : 8'h01 << i);
      chk("gain onehot", {5'h0, FIXED_REF_GAIN_ONEHOT}, (i == 0) ? 8'h00 : 8'h01 << (i - 1));
      chk("gain select", {6'h0, FIXED_REF_GAIN_SELECT}, {6'h0, i[1:0]});
      chk("enable lps nss", {5'h0, DAC_ENABLE, DAC_LOW_POWER_STATE_SELECT, DAC_NEGATIVE_SOURCE_SELECT},
          {5'h0, i[0], i[1], i[0]});
      chk("tap", {2'h0, DAC_TAP}, i[0] ? 8'h15 : (i[1] ? 8'h20 : 8'h00));
    end
    $display("test codes done");
    // Settle flag: early, normal, slow circuit, then switched off
    wr(OFF_FIXED_REFERENCE_CONTROL, 8'h90);
    idle(SETTLE - 4);
    rdchk("flag early", OFF_FIXED_REFERENCE_CONTROL, 8'h90);
    idle(SETTLE + 4);
    rdchk("flag settled", OFF_FIXED_REFERENCE_CONTROL, 8'hd0);
    hold_off <= 1'b1;
    wr(OFF_FIXED_REFERENCE_CONTROL, 8'h10);
    wr(OFF_FIXED_REFERENCE_CONTROL, 8'h90);
    idle(SETTLE + 12);
    rdchk("flag slow circuit", OFF_FIXED_REFERENCE_CONTROL, 8'h90);
    hold_off <= 1'b0;
    idle(6);
    rdchk("flag late", OFF_FIXED_REFERENCE_CONTROL, 8'hd0);
    wr(OFF_FIXED_REFERENCE_CONTROL, 8'h10);
    idle(3);
    rdchk("flag off", OFF_FIXED_REFERENCE_CONTROL, 8'h10);
    chk("fixed enable", {7'h0, FIXED_REF_ENABLE}, 8'h00);
    $display("test settle done");
    // Sleep and wake leave contents alone
    SLEEP <= 1'b1;
    idle(5);
    SLEEP <= 1'b0;
    rdchk("ctrl after wake", OFF_DAC_CONTROL, 8'hcd);
    rdchk("level after wake", OFF_DAC_LEVEL_SELECT, 8'h15);
    $display("test sleep done");
    // Reset in mid-run
    @(posedge CLOCK);
    RST_B <= 1'b0;
    #1 chk("reset outputs", {2'h0, DAC_LEVEL_CODE, DAC_ENABLE}, 8'h00);
    repeat (2) @(posedge CLOCK);
    RST_B <= 1'b1;
    rdchk("level after reset", OFF_DAC_LEVEL_SELECT, 8'h00);
    rdchk("ctrl after reset", OFF_DAC_CONTROL, 8'h00);
    $display("test reset again done");
    complete_run();
  end
endmodule : voltage_reference_control_regs_tb_top

bind voltage_reference_control_regs vref_regs_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_vref_regs_checker (.*);
